// *** pkg/mso_defs.svh ***
`ifndef MSO_DEFS_SVH
`define MSO_DEFS_SVH
// Function codes
`define MSO_FC_RD_COILS     8'h01
`define MSO_FC_RD_DISCRETE  8'h02
`define MSO_FC_RD_HOLDING   8'h03
`define MSO_FC_RD_INPUT     8'h04
`define MSO_FC_WR_COIL      8'h05
`define MSO_FC_WR_REG       8'h06
`define MSO_FC_WR_COILS     8'h0F
`define MSO_FC_WR_REGS      8'h10
// Exception codes
`define MSO_EXC_FUNCTION    8'h01
`define MSO_EXC_ADDRESS     8'h02
// Region bases, zero based numbering
`define MSO_ZB_ALLOC_DI     16'h0000
`define MSO_ZB_ALLOC_HR_IN  16'h0400
`define MSO_ZB_SLOT_DI      16'h0400
`define MSO_ZB_STATUS_DI    16'h0800
`define MSO_ZB_STATUS_IR    16'h0300
`define MSO_ZB_TYPE_IR      16'h0400
`define MSO_ZB_ALLOC_COIL   16'h0000
`define MSO_ZB_ALLOC_HR_OUT 16'h0500
`define MSO_ZB_SLOT_COIL    16'h0400
// Region bases, five digit reference numbering
`define MSO_RF_ALLOC_DI     16'h2711
`define MSO_RF_ALLOC_HR_IN  16'hB3B1
`define MSO_RF_SLOT_DI      16'h32C9
`define MSO_RF_STATUS_DI    16'h36B1
`define MSO_RF_STATUS_IR    16'h8980
`define MSO_RF_TYPE_IR      16'h89E4
`define MSO_RF_ALLOC_COIL   16'h0001
`define MSO_RF_ALLOC_HR_OUT 16'hB415
`define MSO_RF_SLOT_COIL    16'h0BB9
// Spans and layout
`define MSO_BITS_PER_SLOT   16'h0008
`define MSO_IMAGE_BITS      16'h0010
`define MSO_STATUS_BITS     16'h0008
`define MSO_ONE             16'h0001
`define MSO_STAT_FAULT_BIT  8
`define MSO_STAT_WDOG_BIT   9
`define MSO_WD_FAIL_LIMIT   2'h3
// Watchdog timing
`define MSO_WD_TIME_MS      500
`define MSO_CLK_HZ          25000000
// Module type code, value arbitrary
`define MSO_TYPE_WORD       16'h0A5C
`endif

// *** pkg/mso_pkg.sv ***
`default_nettype none
package mso_pkg;
  // One access from the protocol layer
  typedef struct packed {
    logic        valid;
    logic [7:0]  func;
    logic        refNum;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mso_req_t;
  // One answer to the protocol layer
  typedef struct packed {
    logic        valid;
    logic        exc;
    logic [7:0]  excCode;
    logic [15:0] rdata;
  } mso_rsp_t;
  // Result of a region match
  typedef struct packed {
    logic        hit;
    logic [15:0] idx;
  } mso_hit_t;
endpackage
`default_nettype wire

// *** core/mso_address_map.sv ***
// Functional notes
// [R1] Allocated discrete inputs at offset 0
// [R2] Allocated input words as holding registers
// [R3] Slot discrete byte one at base plus 8*slot
// [R4] Slot discrete byte two at 8*(slot+1)
// [R5] Status high byte as slot discrete inputs
// [R6] Status and type words per slot
// [R7] Allocated output coils, codes 5 15 1
// [R8] Allocated output holding registers at 1280
// [R9] Slot output coils at base 1024
// [R10] Direct and reference numbering both accepted
// [R11] Flag breakage or short per channel
// [R12] Disabled monitoring reports no fault
// [R13] Three failures then outputs off 500 ms
// [R14] Input byte: state even, fault odd
// [R15] Master writes value even, invalid odd
// [R16] Invalid flag selects substitute value
// [R17] Bad address or code raises exception
`include "mso_defs.svh"
`default_nettype none
module mso_address_map #(
  // Watchdog delay in clock cycles
  parameter int unsigned WD_CYCLES =
    `MSO_WD_TIME_MS * (`MSO_CLK_HZ / 1000)
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // Placement of this module in the station
  input  wire logic [7:0]        slotNum,
  input  wire logic [15:0]       allocBitBase,
  input  wire logic [15:0]       allocWordBase,
  // Access request and answer
  input  wire mso_pkg::mso_req_t req,
  output var  mso_pkg::mso_rsp_t rsp,
  // Channel configuration
  input  wire logic [7:0]        faultEnable,
  input  wire logic [7:0]        substValue,
  // Line monitoring pins
  input  wire logic [7:0]        lineOpen,
  input  wire logic [7:0]        lineShort,
  // Exchange with the communication unit
  input  wire logic              commAttempt,
  input  wire logic              commOk,
  // Output channels and status
  output logic      [7:0]        channelOut,
  output logic                   wdogTripped
);

  // Offset of an address inside a region under either numbering
  function automatic logic [15:0] relAddr(input logic [15:0] a,
                                          input logic        r,
                                          input logic [15:0] da,
                                          input logic [15:0] rf);
    relAddr = r ? a - rf : a - da; // see [R10]
  endfunction

  // Hit test of an offset against a window of n items
  function automatic mso_pkg::mso_hit_t inWin(input logic [15:0] rel,
                                              input logic [15:0] lo,
                                              input logic [15:0] n);
    logic [15:0] d;
    d         = rel - lo;
    inWin.hit = (rel >= lo) && (d < n);
    inWin.idx = d;
  endfunction

  // Output image written by the master
  logic [15:0] outImage_q;
  logic [15:0] outImage_d;
  // Answer register
  mso_pkg::mso_rsp_t rsp_q;
  mso_pkg::mso_rsp_t rsp_d;
  // Line monitor synchronisers and filtered faults
  logic [7:0]  openS1_q, openS2_q, openS3_q;
  logic [7:0]  shortS1_q, shortS2_q, shortS3_q;
  logic [7:0]  openF_q, shortF_q;
  // Watchdog state
  logic [1:0]  failCnt_q;
  logic [31:0] wdTimer_q;
  logic        wdArmed_q;
  logic        wdTrip_q;
  // Channel drive
  logic [7:0]  chan_q;

  // Slot positions of the two bytes and of the status and type words
  wire [15:0] slotBit  = 16'(slotNum) * `MSO_BITS_PER_SLOT;  // see [R3]
  wire [15:0] slotWord = 16'(slotNum);

  // Line fault per channel, gated by configuration
  wire [7:0] lineFault = (openF_q | shortF_q) & faultEnable; // see [R11]
  // Gate above removes every fault report when monitoring off, see [R12]

  // Input image: state in even bit, fault in odd bit
  logic [15:0] inImage;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      inImage[2*i]   = chan_q[i];    // see [R14]
      inImage[2*i+1] = lineFault[i]; // see [R14]
    end
  end

  // Status word: high byte carries fault summary and watchdog state
  logic [15:0] statusWord;
  always_comb begin
    statusWord                      = 16'h0000;
    statusWord[`MSO_STAT_FAULT_BIT] = |lineFault;
    statusWord[`MSO_STAT_WDOG_BIT]  = wdTrip_q;
  end
  wire [7:0] statusHigh = statusWord[15:8];

  // Region offsets
  wire [15:0] rAllocDi  = relAddr(req.addr, req.refNum,
                            `MSO_ZB_ALLOC_DI, `MSO_RF_ALLOC_DI);
  wire [15:0] rAllocHi  = relAddr(req.addr, req.refNum,
                            `MSO_ZB_ALLOC_HR_IN, `MSO_RF_ALLOC_HR_IN);
  wire [15:0] rSlotDi   = relAddr(req.addr, req.refNum,
                            `MSO_ZB_SLOT_DI, `MSO_RF_SLOT_DI);
  wire [15:0] rStatDi   = relAddr(req.addr, req.refNum,
                            `MSO_ZB_STATUS_DI, `MSO_RF_STATUS_DI);
  wire [15:0] rStatIr   = relAddr(req.addr, req.refNum,
                            `MSO_ZB_STATUS_IR, `MSO_RF_STATUS_IR);
  wire [15:0] rTypeIr   = relAddr(req.addr, req.refNum,
                            `MSO_ZB_TYPE_IR, `MSO_RF_TYPE_IR);
  wire [15:0] rAllocCo  = relAddr(req.addr, req.refNum,
                            `MSO_ZB_ALLOC_COIL, `MSO_RF_ALLOC_COIL);
  wire [15:0] rAllocHo  = relAddr(req.addr, req.refNum,
                            `MSO_ZB_ALLOC_HR_OUT, `MSO_RF_ALLOC_HR_OUT);
  wire [15:0] rSlotCo   = relAddr(req.addr, req.refNum,
                            `MSO_ZB_SLOT_COIL, `MSO_RF_SLOT_COIL);

  // Region hits; sixteen bits span both bytes of the slot pair
  wire mso_pkg::mso_hit_t hAllocDi = inWin(rAllocDi, allocBitBase,
                                           `MSO_IMAGE_BITS); // see [R1]
  wire mso_pkg::mso_hit_t hAllocHi = inWin(rAllocHi, allocWordBase,
                                           `MSO_ONE);        // see [R2]
  wire mso_pkg::mso_hit_t hSlotDi  = inWin(rSlotDi, slotBit,
                                           `MSO_IMAGE_BITS); // see [R4]
  wire mso_pkg::mso_hit_t hStatDi  = inWin(rStatDi, slotBit,
                                           `MSO_STATUS_BITS); // see [R5]
  wire mso_pkg::mso_hit_t hStatIr  = inWin(rStatIr, slotWord,
                                           `MSO_ONE);        // see [R6]
  wire mso_pkg::mso_hit_t hTypeIr  = inWin(rTypeIr, slotWord,
                                           `MSO_ONE);        // see [R6]
  wire mso_pkg::mso_hit_t hAllocCo = inWin(rAllocCo, allocBitBase,
                                           `MSO_IMAGE_BITS); // see [R7]
  wire mso_pkg::mso_hit_t hAllocHo = inWin(rAllocHo, allocWordBase,
                                           `MSO_ONE);        // see [R8]
  wire mso_pkg::mso_hit_t hSlotCo  = inWin(rSlotCo, slotBit,
                                           `MSO_IMAGE_BITS); // see [R9]

  // Decode of the access: answer, exception and image update
  always_comb begin
    rsp_d         = '0;
    rsp_d.valid   = req.valid;
    outImage_d    = outImage_q;
    case (req.func)
      `MSO_FC_RD_DISCRETE: begin
        if (hAllocDi.hit) begin
          rsp_d.rdata = {15'h0000, inImage[hAllocDi.idx[3:0]]}; // see [R1]
        end else if (hSlotDi.hit) begin
          rsp_d.rdata = {15'h0000, inImage[hSlotDi.idx[3:0]]}; // see [R3]
        end else if (hStatDi.hit) begin
          rsp_d.rdata = {15'h0000, statusHigh[hStatDi.idx[2:0]]}; // see [R5]
        end else begin
          rsp_d.exc     = 1'b1; // see [R17]
          rsp_d.excCode = `MSO_EXC_ADDRESS;
        end
      end
      `MSO_FC_RD_HOLDING: begin
        if (hAllocHi.hit) begin
          rsp_d.rdata = inImage;    // see [R2]
        end else if (hAllocHo.hit) begin
          rsp_d.rdata = outImage_q; // see [R8]
        end else begin
          rsp_d.exc     = 1'b1; // see [R17]
          rsp_d.excCode = `MSO_EXC_ADDRESS;
        end
      end
      `MSO_FC_RD_INPUT: begin
        if (hStatIr.hit) begin
          rsp_d.rdata = statusWord;     // see [R6]
        end else if (hTypeIr.hit) begin
          rsp_d.rdata = `MSO_TYPE_WORD; // see [R6]
        end else begin
          rsp_d.exc     = 1'b1; // see [R17]
          rsp_d.excCode = `MSO_EXC_ADDRESS;
        end
      end
      `MSO_FC_RD_COILS: begin
        if (hAllocCo.hit) begin
          rsp_d.rdata = {15'h0000, outImage_q[hAllocCo.idx[3:0]]}; // see [R7]
        end else if (hSlotCo.hit) begin
          rsp_d.rdata = {15'h0000, outImage_q[hSlotCo.idx[3:0]]}; // see [R9]
        end else begin
          rsp_d.exc     = 1'b1; // see [R17]
          rsp_d.excCode = `MSO_EXC_ADDRESS;
        end
      end
      `MSO_FC_WR_COIL, `MSO_FC_WR_COILS: begin
        // Multi coil writes arrive one coil per request
        if (hAllocCo.hit) begin
          outImage_d[hAllocCo.idx[3:0]] = req.wdata[0]; // see [R7]
          rsp_d.rdata = {15'h0000, req.wdata[0]};
        end else if (hSlotCo.hit) begin
          outImage_d[hSlotCo.idx[3:0]] = req.wdata[0]; // see [R9]
          rsp_d.rdata = {15'h0000, req.wdata[0]};
        end else begin
          rsp_d.exc     = 1'b1; // see [R17]
          rsp_d.excCode = `MSO_EXC_ADDRESS;
        end
      end
      `MSO_FC_WR_REG, `MSO_FC_WR_REGS: begin
        // Multi register writes arrive one word per request
        if (hAllocHo.hit) begin
          outImage_d  = req.wdata; // see [R8]
          rsp_d.rdata = req.wdata;
        end else begin
          rsp_d.exc     = 1'b1; // see [R17]
          rsp_d.excCode = `MSO_EXC_ADDRESS;
        end
      end
      default: begin
        rsp_d.exc     = 1'b1; // see [R17]
        rsp_d.excCode = `MSO_EXC_FUNCTION;
      end
    endcase
    // No request, or refused request: image untouched
    if (!req.valid || rsp_d.exc) begin
      outImage_d = outImage_q; // see [R17]
    end
    if (!req.valid) begin
      rsp_d = '0;
    end
  end

  // Output image and answer registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      outImage_q <= 16'h0000;
      rsp_q      <= '0;
    end else begin
      outImage_q <= outImage_d;
      rsp_q      <= rsp_d;
    end
  end

  // Three stage synchronisers on the monitoring pins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      openS1_q  <= 8'h00;
      openS2_q  <= 8'h00;
      openS3_q  <= 8'h00;
      shortS1_q <= 8'h00;
      shortS2_q <= 8'h00;
      shortS3_q <= 8'h00;
    end else begin
      openS1_q  <= lineOpen;
      openS2_q  <= openS1_q;
      openS3_q  <= openS2_q;
      shortS1_q <= lineShort;
      shortS2_q <= shortS1_q;
      shortS3_q <= shortS2_q;
    end
  end

  // Fault taken once second and third stages agree
  wire [7:0] openAgree  = ~(openS2_q ^ openS3_q);
  wire [7:0] shortAgree = ~(shortS2_q ^ shortS3_q);

  // Filtered line faults
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      openF_q  <= 8'h00;
      shortF_q <= 8'h00;
    end else begin
      openF_q  <= (openS3_q & openAgree) | (openF_q & ~openAgree);
      shortF_q <= (shortS3_q & shortAgree) | (shortF_q & ~shortAgree);
    end
  end

  // Failure count reaches its limit on the third failed attempt
  wire failNow   = commAttempt && !commOk;
  wire okNow     = commAttempt && commOk;
  wire thirdFail = failNow && (failCnt_q == `MSO_WD_FAIL_LIMIT - 2'h1);
  wire timerDone = wdArmed_q && (wdTimer_q == WD_CYCLES - 1);

  // Watchdog: arm on third failure, trip after the delay
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      failCnt_q <= 2'h0;
      wdArmed_q <= 1'b0;
      wdTimer_q <= 32'h0000_0000;
      wdTrip_q  <= 1'b0;
    end else if (okNow) begin
      // Good exchange clears the whole sequence
      failCnt_q <= 2'h0;
      wdArmed_q <= 1'b0;
      wdTimer_q <= 32'h0000_0000;
      // Expiry in the same cycle still trips: the set wins
      wdTrip_q  <= timerDone; // see [R13]
    end else begin
      if (failNow && failCnt_q != `MSO_WD_FAIL_LIMIT) begin
        failCnt_q <= failCnt_q + 2'h1;
      end
      if (thirdFail) begin
        wdArmed_q <= 1'b1; // see [R13]
      end
      if (wdArmed_q && !timerDone) begin
        wdTimer_q <= wdTimer_q + 32'h0000_0001; // see [R13]
      end
      if (timerDone) begin
        wdTrip_q  <= 1'b1; // see [R13]
        wdArmed_q <= 1'b0;
      end
    end
  end

  // Channel drive: value or substitute, all off after watchdog trip
  logic [7:0] chanSel;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      chanSel[i] = outImage_q[2*i+1] ? substValue[i] // see [R16]
                                     : outImage_q[2*i]; // see [R15]
    end
  end

  // Channel output register
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      chan_q <= 8'h00;
    end else begin
      chan_q <= wdTrip_q ? 8'h00 : chanSel; // see [R13]
    end
  end

  // Outputs straight from flip-flops
  assign rsp         = rsp_q;
  assign channelOut  = chan_q;
  assign wdogTripped = wdTrip_q;

endmodule // mso_address_map
`default_nettype wire

// *** dv/mso_address_map_props.sv ***
`default_nettype none
module mso_address_map_props #(
  parameter int unsigned WD_CYCLES = 20
) (
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              reset_n,
  // Placement and access
  input wire logic [7:0]        slotNum,
  input wire mso_pkg::mso_req_t req,
  input wire mso_pkg::mso_rsp_t rsp,
  // Monitoring and watchdog
  input wire logic [7:0]        faultEnable,
  input wire logic              commAttempt,
  input wire logic              commOk,
  input wire logic [7:0]        channelOut,
  input wire logic              wdogTripped
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  failCnt_q;  // Consecutive failed exchanges
  logic [1:0]  failCnt_d;
  logic [31:0] armCnt_q;   // Cycles since the third failure
  logic [31:0] armCnt_d;
  logic [15:0] slotW;      // Slot widened to an address
  assign slotW = {8'h00, slotNum};
  assign failCnt_d = !commAttempt ? failCnt_q : commOk ? 2'h0 :
                     (failCnt_q == 2'h3) ? 2'h3 : failCnt_q + 2'h1;
  assign armCnt_d = (failCnt_d != 2'h3) ? 32'h0 : armCnt_q + 32'h1;
  // Failure and arm counters
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      failCnt_q <= 2'h0;
      armCnt_q  <= 32'h0;
    end else begin
      failCnt_q <= failCnt_d;
      armCnt_q  <= armCnt_d;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  type_word_a: assert property (
    req.valid && req.func == 8'h04 && !req.refNum &&
    req.addr == 16'h0400 + slotW |=> rsp.valid && !rsp.exc &&
    rsp.rdata == 16'h0A5C) else $error("type word wrong");
  type_ref_a: assert property (
    req.valid && req.func == 8'h04 && req.refNum &&
    req.addr == 16'h89E4 + slotW |=> rsp.rdata == 16'h0A5C)
    else $error("type word by reference wrong");
  stat_rsvd_a: assert property (
    req.valid && req.func == 8'h04 && req.addr == 16'h0300 + slotW &&
    !req.refNum |=> !rsp.exc && rsp.rdata[15:10] == 6'h00 &&
    rsp.rdata[7:0] == 8'h00) else $error("status spare bits set");
  fault_off_a: assert property (
    (faultEnable == 8'h00)[*6] ##0 (req.valid && req.func == 8'h04 &&
    req.addr == (req.refNum ? 16'h8980 : 16'h0300) + slotW) |=>
    !rsp.rdata[8]) else $error("fault shown while monitoring off");
  bad_func_a: assert property (
    req.valid && !(req.func inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
    8'h06, 8'h0F, 8'h10}) |=> rsp.exc && rsp.excCode == 8'h01)
    else $error("unknown code not refused");
  bad_addr_a: assert property (
    req.valid && req.func == 8'h04 && !req.refNum && req.addr == 16'hFFFF
    |=> rsp.valid && rsp.exc && rsp.excCode == 8'h02)
    else $error("unmapped address not refused");
  wdog_off_a: assert property (
    wdogTripped && !commAttempt |=> channelOut == 8'h00)
    else $error("outputs on while tripped");
  wdog_cause_a: assert property (
    $rose(wdogTripped) |-> $past(failCnt_q) == 2'h3)
    else $error("trip without three failures");
  wdog_time_a: assert property (
    $rose(wdogTripped) |-> $past(armCnt_q) + 32'h3 >= WD_CYCLES &&
    $past(armCnt_q) <= WD_CYCLES + 32'h3) else $error("trip delay wrong");
endmodule // mso_address_map_props
bind mso_address_map mso_address_map_props #(.WD_CYCLES(WD_CYCLES))
  u_props (.ref_clk(ref_clk), .reset_n(reset_n), .slotNum(slotNum),
  .req(req), .rsp(rsp), .faultEnable(faultEnable),
  .commAttempt(commAttempt), .commOk(commOk), .channelOut(channelOut),
  .wdogTripped(wdogTripped));
`default_nettype wire

// *** dv/mso_master_model.sv ***
`default_nettype none
module mso_master_model (
  // Clock
  input  wire logic              ref_clk,
  // Answer from the device
  input  wire mso_pkg::mso_rsp_t rsp,
  // Request to the device
  output var  mso_pkg::mso_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle request at time zero
  initial begin
    req = '0;
  end
  // Hold one request over its taking edge, then take the answer
  task automatic xfer(input logic [7:0] f, input logic rf,
                      input logic [15:0] a, input logic [15:0] d,
                      output mso_pkg::mso_rsp_t s);
    req = {1'b1, f, rf, a, d};
    @(posedge ref_clk);
    #1;
    s = rsp;
    req = {1'b0, ~req[40:0]};  // Released fields do not keep old values
    // One idle edge keeps two requests out of one time step
    @(posedge ref_clk);
    #1;
  endtask
endmodule // mso_master_model
`default_nettype wire

// *** dv/tb_modbus_slot_output_address_map.sv ***
`default_nettype none
module tb_modbus_slot_output_address_map;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int WD = 20;                 // Shortened watchdog delay
  localparam logic [15:0] SLOT16 = 16'h0002;
  localparam logic [15:0] SB = 16'h0010;  // Eight times the slot
  localparam logic [15:0] BB = 16'h0020;  // Allocated bit base
  localparam logic [15:0] WB = 16'h0003;  // Allocated word base
  logic ref_clk, reset_n, commAttempt, commOk, rf;
  logic [7:0] faultEnable, substValue, lineOpen, lineShort, channelOut, ch;
  logic wdogTripped;
  logic [15:0] ow, iw, k;
  logic [31:0] b, seed;
  mso_pkg::mso_req_t req;
  mso_pkg::mso_rsp_t rsp, r;
  int n_mismatch, num_checks, n;
  mso_address_map #(.WD_CYCLES(WD)) uut (.ref_clk(ref_clk),
    .reset_n(reset_n), .slotNum(SLOT16[7:0]), .allocBitBase(BB),
    .allocWordBase(WB), .req(req), .rsp(rsp), .faultEnable(faultEnable),
    .substValue(substValue), .lineOpen(lineOpen), .lineShort(lineShort),
    .commAttempt(commAttempt), .commOk(commOk), .channelOut(channelOut),
    .wdogTripped(wdogTripped));
  mso_master_model master (.ref_clk(ref_clk), .rsp(rsp), .req(req));
  // Compare one value and count it
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Let n edges pass, then step off the edge
  task automatic wt(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic acc(input logic [7:0] f, input logic [15:0] a,
                     input logic [15:0] d);
    master.xfer(f, rf, a, d, r);
  endtask
  // One exchange result from the communication unit
  task automatic pulse(input logic ok);
    commAttempt = 1'b1;
    commOk = ok;
    wt(1);
    commAttempt = 1'b0;
    // Idle cycle between two attempts
    wt(1);
  endtask
  // Address in the numbering chosen by rf
  function automatic logic [15:0] ad(input logic [15:0] d,
                                     input logic [15:0] m,
                                     input logic [15:0] o);
    return (rf ? m : d) + o;
  endfunction
  function automatic logic [7:0] expOut(input logic [15:0] w,
                                        input logic [7:0] sv);
    logic [7:0] o;
    for (int i = 0; i < 8; i++)
      o[i] = w[2*i+1] ? sv[i] : w[2*i];
    return o;
  endfunction
  function automatic logic [15:0] expIn(input logic [7:0] c,
                                        input logic [7:0] ft);
    logic [15:0] w;
    for (int i = 0; i < 8; i++)
      w[2*i+:2] = {ft[i], c[i]};
    return w;
  endfunction
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // Hang guard
  initial begin
    repeat (3000) @(posedge ref_clk);
    n_mismatch++;
    stop_test();
  end
  // Main sequence
  initial begin
    seed = 32'h4EE006D1;
    {reset_n, commAttempt, commOk, rf} = 4'h0;
    {faultEnable, substValue, lineOpen, lineShort} = 32'h0;
    repeat (5) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    chk({7'h0, wdogTripped, channelOut}, 16'h0000);
    for (n = 0; n < 4; n++) begin
      rf = n[0];
      b = $random(seed);
      ow = b[15:0];
      substValue = b[23:16];
      acc(n[1] ? 8'h10 : 8'h06, ad(16'h0500, 16'hB415, WB), ow);
      acc(8'h03, ad(16'h0500, 16'hB415, WB), 16'h0000);
      chk(r.rdata, ow);
      wt(6);
      ch = expOut(ow, substValue);
      chk({8'h00, channelOut}, {8'h00, ch});
      iw = expIn(ch, 8'h00);
      acc(8'h03, ad(16'h0400, 16'hB3B1, WB), 16'h0000);
      chk(r.rdata, iw);
      for (k = 16'h0000; k < 16'h0010; k++) begin
        acc(8'h02, ad(16'h0000, 16'h2711, BB + k), 16'h0000);
        chk(r.rdata, {15'h0, iw[k[3:0]]});
        acc(8'h02, ad(16'h0400, 16'h32C9, SB + k), 16'h0000);
        chk(r.rdata, {15'h0, iw[k[3:0]]});
        acc(8'h01, ad(16'h0000, 16'h0001, BB + k), 16'h0000);
        chk(r.rdata, {15'h0, ow[k[3:0]]});
        acc(8'h01, ad(16'h0400, 16'h0BB9, SB + k), 16'h0000);
        chk(r.rdata, {15'h0, ow[k[3:0]]});
      end
      // Coil writes, allocated single and slot multiple in turn
      for (k = 16'h0000; k < 16'h0010; k++) begin
        b = $random(seed);
        ow[k[3:0]] = b[0];
        acc(k[0] ? 8'h0F : 8'h05, k[0] ? ad(16'h0400, 16'h0BB9, SB + k) :
            ad(16'h0000, 16'h0001, BB + k), {15'h0, b[0]});
      end
      acc(8'h03, ad(16'h0500, 16'hB415, WB), 16'h0000);
      chk(r.rdata, ow);
    end
    rf = 1'b0;
    lineOpen = 8'h01;
    lineShort = 8'h80;
    faultEnable = 8'h7F;
    wt(8);
    acc(8'h03, 16'h0400 + WB, 16'h0000);
    chk(r.rdata, expIn(expOut(ow, substValue), 8'h01));
    acc(8'h04, 16'h0300 + SLOT16, 16'h0000);
    chk(r.rdata, 16'h0100);
    acc(8'h02, 16'h0800 + SB, 16'h0000);
    chk(r.rdata, 16'h0001);
    faultEnable = 8'h00;
    wt(8);
    rf = 1'b1;
    acc(8'h04, 16'h8980 + SLOT16, 16'h0000);
    chk(r.rdata, 16'h0000);
    acc(8'h04, 16'h89E4 + SLOT16, 16'h0000);
    chk(r.rdata, 16'h0A5C);
    rf = 1'b0;
    ch = expOut(ow, substValue);
    acc(8'h04, 16'hFFFF, 16'h0000);
    chk({7'h0, r.exc, r.excCode}, 16'h0102);
    acc(8'h07, 16'h0300, 16'h0000);
    chk({7'h0, r.exc, r.excCode}, 16'h0101);
    acc(8'h05, 16'h0500 + WB, 16'h0001);
    chk({7'h0, r.exc, r.excCode}, 16'h0102);
    acc(8'h06, 16'h0000, 16'hFFFF);
    chk({7'h0, r.exc, r.excCode}, 16'h0102);
    wt(2);
    chk({8'h00, channelOut}, {8'h00, ch});
    acc(8'h06, 16'h0500 + WB, 16'h5555);
    pulse(1'b0);
    pulse(1'b0);
    pulse(1'b1);
    pulse(1'b0);
    pulse(1'b0);
    wt(WD + 8);
    chk({7'h0, wdogTripped, channelOut}, 16'h00FF);
    pulse(1'b0);
    wt(WD - 4);
    chk({15'h0, wdogTripped}, 16'h0000);
    wt(8);
    chk({7'h0, wdogTripped, channelOut}, 16'h0100);
    acc(8'h04, 16'h0300 + SLOT16, 16'h0000);
    chk(r.rdata, 16'h0200);
    pulse(1'b1);
    wt(2);
    chk({7'h0, wdogTripped, channelOut}, 16'h00FF);
    stop_test();
  end
endmodule // tb_modbus_slot_output_address_map
`default_nettype wire
